/* hw/pwig_pkg.sv */
// Purpose: constants for the per-port wake and interrupt gating block
// Assumes: three ports, ports 1 and 2 carry an integrated PHY, port 3 is MAC only
// Notes: register page is address bits 15:12, page value equals the port number
//
// Behaviour
// - magic-packet wake enable bit 2 lets a magic packet drive the power event pin
// - a magic packet counts only if its destination equals the switch MAC address
// - link-up wake enable bit 1 lets link establishment drive the power event pin
// - energy wake enable bit 0 lets cable energy drive the power event pin
// - link-up and energy enables work only on ports with an integrated PHY
// - a cleared enable blocks its detection from the pin; all enables reset to zero
// - status bit 1 is a read-only summary of PHY interrupts, PHY ports only
// - status bit 0 reads one when a rule filter counter entry raises its interrupt
// - rule filter status clears only by toggling its mask bit; status ignores writes
// - mask bits are inverted: zero enables, one disables; both reset to zero
// - rule filter mask exists on all ports, PHY mask acts only on PHY ports
// - status bits reach interrupt signalling only while enabled by their mask bit
// - each port holds write-one-to-clear wake event flags, set whatever the enables; the enables gate them onto the pin
package pwig_pkg;
   localparam int PWIG_NUM_PORTS = 3;
   localparam int PWIG_NUM_PHY_PORTS = 2;
   // address split
   localparam int PWIG_ADDR_W = 16;
   localparam int PWIG_PAGE_MSB = 15;
   localparam int PWIG_PAGE_LSB = 12;
   localparam int PWIG_OFS_W = 12;
   localparam int PWIG_DATA_W = 8;
   localparam logic [3:0] PWIG_GLOBAL_PAGE = 4'h0;
   // per-port register offsets
   localparam logic [11:0] PWIG_OFS_WAKE_EVENT = 12'h013;
   localparam logic [11:0] PWIG_OFS_WAKE_ENABLE = 12'h017;
   localparam logic [11:0] PWIG_OFS_IRQ_STATUS = 12'h01b;
   localparam logic [11:0] PWIG_OFS_IRQ_MASK = 12'h01f;
   // global registers
   localparam logic [11:0] PWIG_OFS_SUMMARY = 12'h010;
   localparam logic [11:0] PWIG_OFS_MAC0 = 12'h302;
   localparam int PWIG_MAC_BYTES = 6;
   // field positions
   localparam int PWIG_BIT_MAGIC = 2;
   localparam int PWIG_BIT_LINK = 1;
   localparam int PWIG_BIT_ENERGY = 0;
   localparam int PWIG_BIT_PHY_IRQ = 1;
   localparam int PWIG_BIT_RULE_IRQ = 0;
   localparam int PWIG_BIT_SUM_PME = 7;
   // reset values
   localparam logic [2:0] PWIG_WAKE_RST = 3'h0;
   localparam logic [1:0] PWIG_MASK_RST = 2'h0;
   localparam logic [7:0] PWIG_MAC_RST = 8'h00;
   localparam logic [7:0] PWIG_RDATA_RST = 8'h00;
endpackage

/* hw/pwig_port_if.sv */
// Purpose: carrier between the top and one port slice
// Assumes: one clock domain, single-cycle strobes
// Notes: rdata is combinational; the top registers it
`timescale 1ns/10ps
`default_nettype none
interface pwig_port_if;
   // register access
   logic wr;
   logic [11:0] ofs;
   logic [7:0] wdata;
   logic [7:0] rdata;
   // detections
   logic magic_hit;
   logic link_up;
   logic energy;
   logic phy_irq;
   logic rule_irq;
   // contributions
   logic power_event_pin;
   logic irq;
   modport top (output wr, ofs, wdata, magic_hit, link_up, energy, phy_irq, rule_irq,
      input rdata, power_event_pin, irq);
   modport port (input wr, ofs, wdata, magic_hit, link_up, energy, phy_irq, rule_irq,
      output rdata, power_event_pin, irq);
endinterface
`default_nettype wire

/* hw/pwig_port.sv */
// Purpose: wake and interrupt gating registers of one switch port
// Assumes: detections are one-cycle pulses from logic on the same clock
// Notes: HAS_PHY selects the PHY-only fields
`timescale 1ns/10ps
`default_nettype none
module pwig_port #(
   parameter bit HAS_PHY = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // top side
   pwig_port_if.port bus
);
   import pwig_pkg::*;

   logic [2:0] wake_event;
   logic [2:0] wake_enable;
   logic rule_status;
   logic [1:0] irq_mask;
   logic [1:0] irq_status;
   logic [2:0] set_event;
   logic [2:0] clr_event;
   logic [2:0] phy_keep;
   logic wr_event, wr_enable, wr_mask, rule_toggle;

   // write decode
   assign wr_event = bus.wr && (bus.ofs == PWIG_OFS_WAKE_EVENT);
   assign wr_enable = bus.wr && (bus.ofs == PWIG_OFS_WAKE_ENABLE);
   assign wr_mask = bus.wr && (bus.ofs == PWIG_OFS_IRQ_MASK);
   // bits that exist on this port; MAC-only port keeps just the magic packet bit
   assign phy_keep = HAS_PHY ? 3'h7 : 3'h4;

   // detections that set the sticky flags
   assign set_event[PWIG_BIT_MAGIC] = bus.magic_hit;
   assign set_event[PWIG_BIT_LINK] = bus.link_up && HAS_PHY;
   assign set_event[PWIG_BIT_ENERGY] = bus.energy && HAS_PHY;
   assign clr_event = wr_event ? bus.wdata[2:0] : 3'h0;

   // sticky wake flags, write one to clear, a new detection wins over the clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wake_event <= PWIG_WAKE_RST;
      end else begin
         wake_event <= ((wake_event & ~clr_event) | set_event) & phy_keep;
      end
   end

   // wake enables
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wake_enable <= PWIG_WAKE_RST;
      end else if (wr_enable) begin
         wake_enable <= bus.wdata[2:0] & phy_keep;
      end
   end

   // inverted-polarity mask; PHY mask bit only held on PHY ports
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_mask <= PWIG_MASK_RST;
      end else if (wr_mask) begin
         irq_mask[PWIG_BIT_RULE_IRQ] <= bus.wdata[PWIG_BIT_RULE_IRQ];
         irq_mask[PWIG_BIT_PHY_IRQ] <= bus.wdata[PWIG_BIT_PHY_IRQ] && HAS_PHY;
      end
   end

   // rule filter status clears only on a change of its mask bit
   assign rule_toggle = wr_mask && (bus.wdata[PWIG_BIT_RULE_IRQ] != irq_mask[PWIG_BIT_RULE_IRQ]);
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rule_status <= 1'b0;
      end else if (bus.rule_irq) begin
         rule_status <= 1'b1;
      end else if (rule_toggle) begin
         rule_status <= 1'b0;
      end
   end

   // status is read-only: PHY summary is a live level, no write path exists
   assign irq_status[PWIG_BIT_PHY_IRQ] = bus.phy_irq && HAS_PHY;
   assign irq_status[PWIG_BIT_RULE_IRQ] = rule_status;

   // contributions to the pin and to the interrupt line
   assign bus.power_event_pin = |(wake_event & wake_enable);
   assign bus.irq = |(irq_status & ~irq_mask);

   // read mux, reserved bits zero
   always_comb begin
      bus.rdata = 8'h00;
      case (bus.ofs)
         PWIG_OFS_WAKE_EVENT: bus.rdata = {5'h00, wake_event};
         PWIG_OFS_WAKE_ENABLE: bus.rdata = {5'h00, wake_enable};
         PWIG_OFS_IRQ_STATUS: bus.rdata = {6'h00, irq_status};
         PWIG_OFS_IRQ_MASK: bus.rdata = {6'h00, irq_mask};
         default: bus.rdata = 8'h00;
      endcase
   end
endmodule
`default_nettype wire

/* hw/pwig_top.sv */
// Purpose: per-port wake and interrupt gating for a three-port switch
// Assumes: detection inputs come from logic on SYS_CLK_I; register port is single-cycle
// Notes: page 0 holds the switch MAC address and a summary; pages 1..3 are the ports
`timescale 1ns/10ps
`default_nettype none
module pwig_top (
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   // register port
   input wire logic [pwig_pkg::PWIG_ADDR_W-1:0] REG_ADDR_I,
   input wire logic [pwig_pkg::PWIG_DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [pwig_pkg::PWIG_DATA_W-1:0] REG_RDATA_O,
   // detections, bit i is port i+1
   input wire logic [pwig_pkg::PWIG_NUM_PORTS-1:0] MAGIC_DET_I,
   input wire logic [pwig_pkg::PWIG_NUM_PORTS*48-1:0] MAGIC_DA_I,
   input wire logic [pwig_pkg::PWIG_NUM_PORTS-1:0] LINK_UP_I,
   input wire logic [pwig_pkg::PWIG_NUM_PORTS-1:0] ENERGY_I,
   input wire logic [pwig_pkg::PWIG_NUM_PORTS-1:0] PHY_IRQ_I,
   input wire logic [pwig_pkg::PWIG_NUM_PORTS-1:0] RULE_IRQ_I,
   // outputs to the host
   output logic POWER_EVENT_PIN_O,
   output logic IRQ_O
);
   import pwig_pkg::*;

   logic [3:0] page;
   logic [11:0] ofs;
   logic [7:0] mac_addr [PWIG_MAC_BYTES];
   logic [47:0] mac_flat;
   logic [PWIG_NUM_PORTS-1:0] port_pme;
   logic [PWIG_NUM_PORTS-1:0] port_irq;
   logic [7:0] port_rdata [PWIG_NUM_PORTS];
   logic [7:0] next_rdata;
   logic glob_wr;

   pwig_port_if port_bus [PWIG_NUM_PORTS] ();

   // address split
   assign page = REG_ADDR_I[PWIG_PAGE_MSB:PWIG_PAGE_LSB];
   assign ofs = REG_ADDR_I[PWIG_OFS_W-1:0];
   assign glob_wr = REG_WR_I && (page == PWIG_GLOBAL_PAGE);

   // switch MAC address bytes, byte 0 is the most significant
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         for (int b = 0; b < PWIG_MAC_BYTES; b++) begin
            mac_addr[b] <= PWIG_MAC_RST;
         end
      end else if (glob_wr) begin
         for (int b = 0; b < PWIG_MAC_BYTES; b++) begin
            if (ofs == PWIG_OFS_MAC0 + 12'(b)) begin
               mac_addr[b] <= REG_WDATA_I;
            end
         end
      end
   end
   assign mac_flat = {mac_addr[0], mac_addr[1], mac_addr[2],
      mac_addr[3], mac_addr[4], mac_addr[5]};

   // one slice per port; ports below the PHY count have an integrated PHY
   for (genvar i = 0; i < PWIG_NUM_PORTS; i++) begin : g_port
      assign port_bus[i].wr = REG_WR_I && (page == 4'(i + 1));
      assign port_bus[i].ofs = ofs;
      assign port_bus[i].wdata = REG_WDATA_I;
      // destination must match the switch address to count as a wake packet
      assign port_bus[i].magic_hit = MAGIC_DET_I[i] &&
         (MAGIC_DA_I[i*48 +: 48] == mac_flat);
      assign port_bus[i].link_up = LINK_UP_I[i];
      assign port_bus[i].energy = ENERGY_I[i];
      assign port_bus[i].phy_irq = PHY_IRQ_I[i];
      assign port_bus[i].rule_irq = RULE_IRQ_I[i];
      assign port_pme[i] = port_bus[i].power_event_pin;
      assign port_irq[i] = port_bus[i].irq;
      assign port_rdata[i] = port_bus[i].rdata;
      pwig_port #(
         .HAS_PHY(i < PWIG_NUM_PHY_PORTS)
      ) u_port (
         .clk_i(SYS_CLK_I),
         .rstn_i(RSTN_I),
         .bus(port_bus[i])
      );
   end

   // read select; unmapped addresses answer zero
   always_comb begin
      next_rdata = 8'h00;
      if (page == PWIG_GLOBAL_PAGE) begin
         if (ofs == PWIG_OFS_SUMMARY) begin
            next_rdata = {POWER_EVENT_PIN_O, 4'h0, port_irq};
         end
         for (int b = 0; b < PWIG_MAC_BYTES; b++) begin
            if (ofs == PWIG_OFS_MAC0 + 12'(b)) begin
               next_rdata = mac_addr[b];
            end
         end
      end else begin
         for (int p = 0; p < PWIG_NUM_PORTS; p++) begin
            if (page == 4'(p + 1)) begin
               next_rdata = port_rdata[p];
            end
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         REG_RDATA_O <= PWIG_RDATA_RST;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= next_rdata;
      end else begin
         REG_RDATA_O <= PWIG_RDATA_RST;
      end
   end

   // outputs registered so the pin never glitches on a decode change
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         POWER_EVENT_PIN_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         POWER_EVENT_PIN_O <= |port_pme;
         IRQ_O <= |port_irq;
      end
   end
endmodule
`default_nettype wire

/* testbench/pwig_monitor.sv */
// Purpose: port-level checks for pwig_top
// Assumes: one clock, synchronous active-low reset
// Notes: shadows port 1 enable and mask to know the gating
`timescale 1ns/10ps
`default_nettype none
module pwig_monitor (
   // clock, reset and register port
   input wire logic SYS_CLK_I, RSTN_I, REG_WR_I, REG_RD_I,
   input wire logic [15:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I, REG_RDATA_O,
   // detections and outputs
   input wire logic [2:0] MAGIC_DET_I, LINK_UP_I, ENERGY_I, PHY_IRQ_I, RULE_IRQ_I,
   input wire logic POWER_EVENT_PIN_O, IRQ_O
);
   logic [2:0] en1;
   logic [1:0] m1;
   // port 1 shadow only, keeps the helper small
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         en1 <= 3'h0;
         m1 <= 2'h0;
      end else if (REG_WR_I && REG_ADDR_I == 16'h1017) begin
         en1 <= REG_WDATA_I[2:0];
      end else if (REG_WR_I && REG_ADDR_I == 16'h101f) begin
         m1 <= REG_WDATA_I[1:0];
      end
   end
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RSTN_I);
   property p_rst; disable iff (1'b0) !RSTN_I |=> !POWER_EVENT_PIN_O && !IRQ_O; endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
   property p_pin_up; $rose(POWER_EVENT_PIN_O) |->
      $past({MAGIC_DET_I, LINK_UP_I[1:0], ENERGY_I[1:0]} != 7'h0, 2) || $past(REG_WR_I, 2);
   endproperty
   a_pin_up: assert property (p_pin_up) else $error("pin rose without cause");
   property p_pin_dn; $fell(POWER_EVENT_PIN_O) && $past(RSTN_I) |-> $past(REG_WR_I, 2);
   endproperty
   a_pin_dn: assert property (p_pin_dn) else $error("pin fell without write");
   property p_irq_up; $rose(IRQ_O) |-> $past(PHY_IRQ_I[1:0] != 2'h0) ||
      $past(RULE_IRQ_I != 3'h0, 2) || $past(REG_WR_I, 2); endproperty
   a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
   property p_rule; RULE_IRQ_I[0] && !m1[0] && !REG_WR_I |-> ##2 IRQ_O; endproperty
   a_rule: assert property (p_rule) else $error("rule event lost");
   property p_phy; PHY_IRQ_I[0] && !m1[1] |=> IRQ_O; endproperty
   a_phy: assert property (p_phy) else $error("phy event lost");
   property p_energy; ENERGY_I[0] && en1[0] && !REG_WR_I |-> ##2 POWER_EVENT_PIN_O; endproperty
   a_energy: assert property (p_energy) else $error("energy wake lost");
   property p_link; LINK_UP_I[0] && en1[1] && !REG_WR_I |-> ##2 POWER_EVENT_PIN_O; endproperty
   a_link: assert property (p_link) else $error("link wake lost");
   // port pages hold at most three live bits, the rest must answer zero
   property p_rsvd; $past(REG_RD_I) && $past(REG_ADDR_I[15:12] != 4'h0) |->
      REG_RDATA_O[7:3] == 5'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule
bind pwig_top pwig_monitor u_mon (.SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .REG_WR_I(REG_WR_I),
   .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
   .MAGIC_DET_I(MAGIC_DET_I), .LINK_UP_I(LINK_UP_I), .ENERGY_I(ENERGY_I), .REG_RD_I(REG_RD_I),
   .PHY_IRQ_I(PHY_IRQ_I), .RULE_IRQ_I(RULE_IRQ_I), .POWER_EVENT_PIN_O(POWER_EVENT_PIN_O),
   .IRQ_O(IRQ_O));
`default_nettype wire

/* testbench/pwig_host_model.sv */
// Purpose: host that watches the power event pin and the interrupt
// Assumes: host samples both levels on the system clock
// Notes: latches what it saw so the bench can ask later
`timescale 1ns/10ps
`default_nettype none
module pwig_host_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // levels from the device
   input wire logic power_event_i,
   input wire logic irq_i,
   // what the host saw
   output logic wake_seen_o,
   output logic irq_seen_o
);
   // sticky capture, a short level must not be missed
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wake_seen_o <= 1'b0;
         irq_seen_o <= 1'b0;
      end else begin
         wake_seen_o <= wake_seen_o | power_event_i;
         irq_seen_o <= irq_seen_o | irq_i;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_pwig_top.sv */
// Purpose: self-checking bench for pwig_top
// Assumes: 10 MHz clock, reset held 5 cycles
// Notes: register rows first, event cases by hand after
`timescale 1ns/10ps
`default_nettype none
module tb_pwig_top;
   logic clk, rst_n, wr, rd, pin, irq, wake_seen, irq_seen;
   logic [15:0] addr;
   logic [7:0] wdata, rdata;
   logic [2:0] magic, link, energy, phy, rule;
   logic [143:0] da;
   // address, write data, expected readback
   logic [31:0] rows [9] = '{32'h1017ff07, 32'h3017ff04, 32'h101fff03, 32'h301fff01,
      32'h101bff00, 32'h14005a00, 32'h201f0303, 32'h101f0000, 32'h301f0000};
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   pwig_top dut (.SYS_CLK_I(clk), .RSTN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
      .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .MAGIC_DET_I(magic),
      .MAGIC_DA_I(da), .LINK_UP_I(link), .ENERGY_I(energy), .PHY_IRQ_I(phy),
      .RULE_IRQ_I(rule), .POWER_EVENT_PIN_O(pin), .IRQ_O(irq));
   pwig_host_model host (.clk_i(clk), .rstn_i(rst_n), .power_event_i(pin), .irq_i(irq),
      .wake_seen_o(wake_seen), .irq_seen_o(irq_seen));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // each bus task starts 1 ns after an edge so strobes never toggle twice in a step
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      #1 wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
      #1 rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp, what);
   endtask
   // one-cycle detection pulse, bits are rule, magic, link, energy per port
   task automatic det(input logic [11:0] v);
      #1 {rule, magic, link, energy} <= v;
      @(posedge clk);
      {rule, magic, link, energy} <= 12'h000;
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always #50 clk = ~clk;
   // hang guard, the run needs about a hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      {clk, rst_n, wr, rd, addr, wdata, magic, link, energy, phy, rule, da} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(16'h1017, 8'h00, "enable");
      rchk(16'h101f, 8'h00, "mask");
      foreach (rows[i]) begin
         wreg(rows[i][31:16], rows[i][15:8]);
         rchk(rows[i][31:16], rows[i][7:0], "row");
      end
      for (int i = 0; i < 6; i++) wreg(16'h0302 + 16'(i), 8'h10 + 8'(i));
      rchk(16'h0305, 8'h13, "mac byte 3");
      da[47:0] <= 48'h101112131416;
      det(12'h040);
      @(posedge clk);
      rchk(16'h1013, 8'h00, "foreign address");
      da[47:0] <= 48'h101112131415;
      // energy, link, magic on port 1 in turn
      for (int k = 0; k < 3; k++) begin
         det(12'h001 << (3 * k));
         @(posedge clk);
         #1 check({7'h0, pin}, 8'h01, "pin");
         rchk(16'h1013, 8'h01 << k, "flag");
         wreg(16'h1013, 8'h01 << k);
         @(posedge clk);
         #1 check({7'h0, pin}, 8'h00, "pin cleared");
      end
      check({7'h0, wake_seen}, 8'h01, "host wake");
      det(12'h024);
      @(posedge clk);
      rchk(16'h3013, 8'h00, "mac port flags");
      check({7'h0, pin}, 8'h00, "mac port pin");
      // the MAC-only port still keeps its magic packet wake
      da[143:96] <= 48'h101112131415;
      det(12'h100);
      @(posedge clk);
      #1 check({7'h0, pin}, 8'h01, "mac port magic");
      wreg(16'h3013, 8'h04);
      wreg(16'h1017, 8'h00);
      det(12'h001);
      repeat (2) @(posedge clk);
      #1 check({7'h0, pin}, 8'h00, "gated pin");
      wreg(16'h1017, 8'h01);
      @(posedge clk);
      #1 check({7'h0, pin}, 8'h01, "late enable");
      rchk(16'h0010, 8'h80, "summary pin");
      // detection and clear in one cycle, the detection must win
      #1 {wr, addr, wdata, energy} <= {1'b1, 16'h1013, 8'h01, 3'h1};
      @(posedge clk);
      {wr, energy} <= 4'h0;
      rchk(16'h1013, 8'h01, "set beats clear");
      wreg(16'h1013, 8'h01);
      det(12'h200);
      @(posedge clk);
      #1 check({7'h0, irq}, 8'h01, "rule irq");
      wreg(16'h101b, 8'h00);
      rchk(16'h101b, 8'h01, "rule status");
      wreg(16'h101f, 8'h01);
      rchk(16'h101b, 8'h00, "toggled status");
      det(12'h200);
      repeat (2) @(posedge clk);
      #1 check({7'h0, irq}, 8'h00, "masked irq");
      wreg(16'h101f, 8'h00);
      rchk(16'h101b, 8'h00, "toggled back");
      // rule event and mask toggle in one cycle, the event must win
      #1 {wr, addr, wdata, rule} <= {1'b1, 16'h101f, 8'h01, 3'h1};
      @(posedge clk);
      {wr, rule} <= 4'h0;
      rchk(16'h101b, 8'h01, "rule beats toggle");
      wreg(16'h101f, 8'h00);
      rchk(16'h101b, 8'h00, "toggle clears again");
      phy <= 3'b101;
      repeat (2) @(posedge clk);
      #1 check({7'h0, irq}, 8'h01, "phy irq");
      rchk(16'h101b, 8'h02, "phy status");
      rchk(16'h0010, 8'h01, "summary irq");
      rchk(16'h301b, 8'h00, "mac port status");
      wreg(16'h101f, 8'h02);
      @(posedge clk);
      #1 check({7'h0, irq}, 8'h00, "phy masked");
      check({7'h0, irq_seen}, 8'h01, "host irq");
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rchk(16'h1017, 8'h00, "enable after reset");
      rchk(16'h101f, 8'h00, "mask after reset");
      // phy level still high and mask back to enabled, so the line comes straight back
      check({7'h0, irq}, 8'h01, "phy irq after reset");
      test_done();
   end
endmodule
`default_nettype wire
